// File: verilog/bst_pkg.sv
// Package of constants and types shared by the buffer self-test block.
package bst_pkg;

  // ---------------------------------------------------------------
  // Buffer geometry
  // ---------------------------------------------------------------
  localparam int          BST_ADDR_W    = 13;
  localparam int          BST_DATA_W    = 8;
  localparam logic [12:0] BST_FIRST_ADDR = 13'h0000;
  localparam logic [12:0] BST_LAST_ADDR  = 13'h1fff;

  // ---------------------------------------------------------------
  // Register offsets on the plain register port
  // ---------------------------------------------------------------
  localparam int         BST_REG_ADDR_W = 4;
  localparam logic [3:0] BST_OFS_CTRL   = 4'h0;
  localparam logic [3:0] BST_OFS_SEED   = 4'h1;
  localparam logic [3:0] BST_OFS_SUM_LO = 4'h2;
  localparam logic [3:0] BST_OFS_SUM_HI = 4'h3;

  // ---------------------------------------------------------------
  // Control register field positions
  // ---------------------------------------------------------------
  localparam int BST_BIT_BUSY  = 0;
  localparam int BST_BIT_MODE  = 1;
  localparam int BST_FT_LSB    = 2;
  localparam int BST_BIT_SWAP  = 4;
  localparam int BST_SHIFT_LSB = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  BST_CTRL_RST  = 8'h00;
  localparam logic [7:0]  BST_SEED_RST  = 8'h00;
  localparam logic [15:0] BST_SUM_RST   = 16'h0000;

  // Feedback taps of the random generator; a zero state stays zero.
  localparam logic [7:0]  BST_LFSR_TAPS = 8'hb8;

  // Fill type encoding as held in the control register.
  typedef enum logic [1:0] {
    BST_FILL_RANDOM  = 2'b00,
    BST_FILL_ADDRESS = 2'b01,
    BST_FILL_PATTERN = 2'b10,
    BST_FILL_RSVD    = 2'b11
  } bst_fill_e;

endpackage : bst_pkg

// File: verilog/bst_gen.sv
// Next fill-seed generator: random step or pattern rotation.
module bst_gen
  import bst_pkg::*;
(
  input  wire logic [7:0]       seed,
  input  bst_pkg::bst_fill_e    fill_type_select,
  input  wire logic [2:0]       shift_amount,
  output logic      [7:0]       next_seed
);

  // Rotate left; bits leaving the top come back in at the bottom.
  function automatic logic [7:0] bst_rotl(input logic [7:0] v, input logic [2:0] n);
    logic [15:0] tmp;
    tmp = {v, v} << n;
    return tmp[15:8];
  endfunction

  // Galois step; with no ones in the state nothing is fed back.
  function automatic logic [7:0] bst_lfsr(input logic [7:0] v);
    return v[0] ? ((v >> 1) ^ BST_LFSR_TAPS) : (v >> 1);
  endfunction

  // ---------------------------------------------------------------
  // Seed update per written location
  // ---------------------------------------------------------------
  always_comb
  begin
    unique case (fill_type_select)
      BST_FILL_RANDOM:  next_seed = bst_lfsr(seed);
      BST_FILL_PATTERN: next_seed = bst_rotl(seed, shift_amount);
      default:          next_seed = seed;
    endcase
  end

endmodule // bst_gen

// File: verilog/bst_csum.sv
// Running one's complement checksum over a byte stream.
module bst_csum
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clear,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_in,
  output logic      [15:0] checksum
);

  logic [15:0] sum_ff;
  logic [7:0]  hi_ff;
  logic        odd_ff;

  // End-around carry add; the folded carry cannot overflow again.
  function automatic logic [15:0] bst_add1c(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  // ---------------------------------------------------------------
  // Byte pairing: even bytes are the high half of a word
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst || clear)
    begin
      sum_ff <= 16'h0000;
      hi_ff  <= 8'h00;
      odd_ff <= 1'b0;
    end
    else if (byte_valid)
    begin
      odd_ff <= ~odd_ff;
      if (!odd_ff)
        hi_ff <= byte_in;
      else
        sum_ff <= bst_add1c(sum_ff, {hi_ff, byte_in});
    end
  end

  // A pending odd byte is padded with a zero low half.
  assign checksum = odd_ff ? ~bst_add1c(sum_ff, {hi_ff, 8'h00}) : ~sum_ff;

endmodule // bst_csum

// File: verilog/bst_top.sv
// Buffer memory self-test controller with register port and SRAM port steering.
//
// Our own choices: the strobed register port and the address map.

// Notes on behaviour
// - A started test writes every buffer byte and loads its checksum at the end.
// - Pattern-shift mode rotates the seed left by the shift amount; other modes ignore it.
// - Port-select set swaps the SRAM ports used by self-test and copy engine.
// - Fill type: 00 random, 01 address, 10 pattern shift, 11 reserved.
// - Test-mode enable bit turns test mode on when one, off when zero.
// - Start/busy reads one while running and clears itself when the fill ends.
// - One byte is written to the buffer on every clock while filling, none in the closing done cycle.
// - Random fill uses an LFSR seeded from the seed register, left updated.
// - A zero seed gives all-zero data; equal seeds give equal sequences.
// - Address fill stores the low address byte into each location.
// - A full address fill always yields checksum F807h.
// - Clearing either start/busy or test-mode enable aborts the fill; copy start is not decoded here.
// - Copy engine reads at the fill byte rate, so may start any time after.
// - Pattern fill writes the seed at 0000h, then rotates left per address.
// - Checksum is one's complement of big-endian 16-bit word sum, zero padded.
module bst_top
  import bst_pkg::*;
(
  input  wire logic                                clock,
  input  wire logic                                sys_rst,
  // Register port.
  input  wire logic [bst_pkg::BST_REG_ADDR_W-1:0]  reg_addr,
  input  wire logic [7:0]                          reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [7:0]                          reg_rdata,
  // Copy engine access request.
  input  wire logic [bst_pkg::BST_ADDR_W-1:0]      dma_addr,
  input  wire logic                                dma_re,
  output logic      [7:0]                          dma_rdata,
  // SRAM port A.
  output logic      [bst_pkg::BST_ADDR_W-1:0]      port_a_addr,
  output logic      [7:0]                          port_a_wdata,
  output logic                                     port_a_we,
  output logic                                     port_a_re,
  input  wire logic [7:0]                          port_a_rdata,
  // SRAM port B.
  output logic      [bst_pkg::BST_ADDR_W-1:0]      port_b_addr,
  output logic      [7:0]                          port_b_wdata,
  output logic                                     port_b_we,
  output logic                                     port_b_re,
  input  wire logic [7:0]                          port_b_rdata,
  // Status.
  output logic                                     test_mode,
  output logic                                     test_busy,
  output logic                                     port_swap
);
  import bst_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BST_ST_IDLE,
    BST_ST_FILL,
    BST_ST_DONE
  } bst_state_e;

  bst_state_e               state_ff;
  logic [2:0]               shift_amount_ff;
  logic                     swap_ff;
  bst_fill_e                fill_type_ff;
  logic                     mode_ff;
  logic                     busy_ff;
  logic [7:0]               fill_seed_ff;
  logic [15:0]              sum_ff;
  logic [BST_ADDR_W-1:0]    fill_addr_ff;
  logic [7:0]               reg_rdata_ff;
  logic [BST_ADDR_W-1:0]    pa_addr_ff;
  logic [7:0]               pa_wdata_ff;
  logic                     pa_we_ff;
  logic                     pa_re_ff;
  logic [BST_ADDR_W-1:0]    pb_addr_ff;
  logic [7:0]               pb_wdata_ff;
  logic                     pb_we_ff;
  logic                     pb_re_ff;
  logic [7:0]               dma_rdata_ff;

  logic                     wr_ctrl;
  logic                     wr_seed;
  logic                     start_req;
  logic                     abort_req;
  logic                     fill_we;
  logic [7:0]               fill_byte;
  logic [7:0]               nxt_fill_seed;
  logic [15:0]              run_sum;
  bst_fill_e                wr_fill_type;

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------

  // Write strobes per register.
  assign wr_ctrl      = reg_wr && (reg_addr == BST_OFS_CTRL);
  assign wr_seed      = reg_wr && (reg_addr == BST_OFS_SEED);
  assign wr_fill_type = bst_fill_e'(reg_wdata[BST_FT_LSB +: 2]);

  // A start needs test mode in the same write and a defined fill type.
  // Reserved fill type is refused so the fill never runs with no data source.
  assign start_req = wr_ctrl && (state_ff == BST_ST_IDLE)
                   && reg_wdata[BST_BIT_BUSY] && reg_wdata[BST_BIT_MODE]
                   && (wr_fill_type != BST_FILL_RSVD);

  // Dropping either start/busy or test mode while filling cancels the test.
  // The copy engine start bit lives outside this block and is the host's.
  assign abort_req = wr_ctrl && (state_ff == BST_ST_FILL)
                   && (!reg_wdata[BST_BIT_BUSY] || !reg_wdata[BST_BIT_MODE]);

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------

  // Configuration fields; all clear after reset.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      shift_amount_ff <= BST_CTRL_RST[BST_SHIFT_LSB +: 3];
      swap_ff         <= BST_CTRL_RST[BST_BIT_SWAP];
      fill_type_ff    <= bst_fill_e'(BST_CTRL_RST[BST_FT_LSB +: 2]);
      mode_ff         <= BST_CTRL_RST[BST_BIT_MODE];
    end
    else if (wr_ctrl)
    begin
      shift_amount_ff <= reg_wdata[BST_SHIFT_LSB +: 3];
      swap_ff         <= reg_wdata[BST_BIT_SWAP];
      fill_type_ff    <= wr_fill_type;
      mode_ff         <= reg_wdata[BST_BIT_MODE];
    end
  end

  // Start/busy flag: set by a legal start, cleared by abort or completion.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      busy_ff <= BST_CTRL_RST[BST_BIT_BUSY];
    else if (start_req)
      busy_ff <= 1'b1;
    else if (abort_req || (state_ff == BST_ST_DONE))
      busy_ff <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Fill sequencer
  // ---------------------------------------------------------------

  // Idle until started, fill to the last address, then load the checksum.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      state_ff <= BST_ST_IDLE;
    else
    begin
      unique case (state_ff)
        BST_ST_IDLE:
          if (start_req)
            state_ff <= BST_ST_FILL;
        BST_ST_FILL:
          if (abort_req)
            state_ff <= BST_ST_IDLE;
          else if (fill_addr_ff == BST_LAST_ADDR)
            state_ff <= BST_ST_DONE;
        BST_ST_DONE:
          state_ff <= BST_ST_IDLE;
      endcase
    end
  end

  // Address walks upward by one each clock so every byte is hit once.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      fill_addr_ff <= BST_FIRST_ADDR;
    else if (start_req)
      fill_addr_ff <= BST_FIRST_ADDR;
    else if (state_ff == BST_ST_FILL)
      fill_addr_ff <= fill_addr_ff + 13'h0001;
  end

  // One byte per clock while filling, none in the cycle an abort lands.
  assign fill_we = (state_ff == BST_ST_FILL) && !abort_req;

  // Address fill writes the low address byte; other modes write the seed.
  assign fill_byte = (fill_type_ff == BST_FILL_ADDRESS)
                   ? fill_addr_ff[7:0]
                   : fill_seed_ff;

  // ---------------------------------------------------------------
  // Seed register and data generator
  // ---------------------------------------------------------------

  bst_gen u_gen (
    .seed             (fill_seed_ff),
    .fill_type_select (fill_type_ff),
    .shift_amount     (shift_amount_ff),
    .next_seed        (nxt_fill_seed)
  );

  // The seed steps after each written byte, so it ends holding the
  // generator state. A host write wins, but the host must not write here
  // during a fill or the sequence is no longer repeatable.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      fill_seed_ff <= BST_SEED_RST;
    else if (wr_seed)
      fill_seed_ff <= reg_wdata;
    else if (fill_we)
      fill_seed_ff <= nxt_fill_seed;
  end

  // ---------------------------------------------------------------
  // Checksum
  // ---------------------------------------------------------------

  bst_csum u_csum (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .clear      (start_req),
    .byte_valid (fill_we),
    .byte_in    (fill_byte),
    .checksum   (run_sum)
  );

  // The last byte is folded in by the time the sequencer reaches done.
  // An aborted test leaves the previous result untouched.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      sum_ff <= BST_SUM_RST;
    else if (state_ff == BST_ST_DONE)
      sum_ff <= run_sum;
  end

  // ---------------------------------------------------------------
  // SRAM port steering
  // ---------------------------------------------------------------

  // Normally port A serves the fill and port B the copy engine; the swap
  // bit reverses them. Both paths are registered, which costs a cycle of
  // latency but keeps every port a clean flop output. Since the copy engine
  // reads at the same byte rate, it trails the fill by a fixed distance.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pa_addr_ff <= BST_FIRST_ADDR;
      pa_we_ff   <= 1'b0;
      pa_re_ff   <= 1'b0;
      pb_addr_ff <= BST_FIRST_ADDR;
      pb_we_ff   <= 1'b0;
      pb_re_ff   <= 1'b0;
    end
    else if (swap_ff)
    begin
      pa_addr_ff <= dma_addr;
      pa_we_ff   <= 1'b0;
      pa_re_ff   <= dma_re;
      pb_addr_ff <= fill_addr_ff;
      pb_we_ff   <= fill_we;
      pb_re_ff   <= 1'b0;
    end
    else
    begin
      pa_addr_ff <= fill_addr_ff;
      pa_we_ff   <= fill_we;
      pa_re_ff   <= 1'b0;
      pb_addr_ff <= dma_addr;
      pb_we_ff   <= 1'b0;
      pb_re_ff   <= dma_re;
    end
  end

  // Write data goes to both ports; only the enabled one stores it.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pa_wdata_ff <= 8'h00;
      pb_wdata_ff <= 8'h00;
    end
    else
    begin
      pa_wdata_ff <= fill_byte;
      pb_wdata_ff <= fill_byte;
    end
  end

  // Return read data from whichever port the copy engine owns.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      dma_rdata_ff <= 8'h00;
    else
      dma_rdata_ff <= swap_ff ? port_a_rdata : port_b_rdata;
  end

  // ---------------------------------------------------------------
  // Register read-back
  // ---------------------------------------------------------------

  // Data stands only in the cycle after the read strobe; zero otherwise.
  always_ff @(posedge clock)
  begin
    if (sys_rst || !reg_rd)
      reg_rdata_ff <= 8'h00;
    else
    begin
      unique case (reg_addr)
        BST_OFS_CTRL:   reg_rdata_ff <= {shift_amount_ff, swap_ff, fill_type_ff,
                                         mode_ff, busy_ff};
        BST_OFS_SEED:   reg_rdata_ff <= fill_seed_ff;
        BST_OFS_SUM_LO: reg_rdata_ff <= sum_ff[7:0];
        BST_OFS_SUM_HI: reg_rdata_ff <= sum_ff[15:8];
        default:        reg_rdata_ff <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata    = reg_rdata_ff;
  assign dma_rdata    = dma_rdata_ff;
  assign port_a_addr  = pa_addr_ff;
  assign port_a_wdata = pa_wdata_ff;
  assign port_a_we    = pa_we_ff;
  assign port_a_re    = pa_re_ff;
  assign port_b_addr  = pb_addr_ff;
  assign port_b_wdata = pb_wdata_ff;
  assign port_b_we    = pb_we_ff;
  assign port_b_re    = pb_re_ff;
  assign test_mode    = mode_ff;
  assign test_busy    = busy_ff;
  assign port_swap    = swap_ff;

endmodule // bst_top

// File: tb/bst_top_props.sv
// Concurrent checks on the buffer self-test block, bound to its top module.
module bst_top_props
  import bst_pkg::*;
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic [12:0] dma_addr,
  input wire logic        dma_re,
  input wire logic [12:0] port_a_addr,
  input wire logic [7:0]  port_a_wdata,
  input wire logic        port_a_we,
  input wire logic        port_a_re,
  input wire logic [12:0] port_b_addr,
  input wire logic [7:0]  port_b_wdata,
  input wire logic        port_b_we,
  input wire logic        port_b_re,
  input wire logic        test_mode,
  input wire logic        test_busy,
  input wire logic        port_swap
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------
  logic [12:0] f_addr;
  logic [7:0]  f_data;
  logic        f_we;
  logic        ctl_wr;
  logic [1:0]  type_ff;
  logic [2:0]  shift_ff;
  logic [13:0] cnt_ff;
  logic        abort_ff;

  // The fill owns port A unless swapped, so a wrong steer starves these views.
  assign f_we   = port_swap ? port_b_we : port_a_we;
  assign f_addr = port_swap ? port_b_addr : port_a_addr;
  assign f_data = port_swap ? port_b_wdata : port_a_wdata;
  assign ctl_wr = reg_wr && reg_addr == BST_OFS_CTRL;

  function automatic logic [7:0] rotl(logic [7:0] d, logic [2:0] s);
    logic [15:0] t;
    t = {d, d} << s;
    return t[15:8];
  endfunction

  // Fill type and shift are not ports, so they are mirrored from control writes.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      type_ff  <= 2'h0;
      shift_ff <= 3'h0;
    end
    else if (ctl_wr)
    begin
      type_ff  <= reg_wdata[3:2];
      shift_ff <= reg_wdata[7:5];
    end
  end

  // Counts fill writes of one test; a control write while busy marks an abort.
  always_ff @(posedge clock)
  begin
    if (sys_rst || !test_busy)
    begin
      cnt_ff   <= 14'h0;
      abort_ff <= 1'b0;
    end
    else
    begin
      cnt_ff   <= cnt_ff + {13'h0, f_we};
      abort_ff <= abort_ff | ctl_wr;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  chk_start_taken:
    assert property (ctl_wr && reg_wdata[1:0] == 2'h3 && reg_wdata[3:2] != 2'h3 && !test_busy
      |=> test_busy) else $error("start write did not raise busy");
  chk_start_refused:
    assert property (ctl_wr && (reg_wdata[3:2] == 2'h3 || !reg_wdata[1]) && !test_busy
      |=> !test_busy) else $error("refused start raised busy");
  chk_ctrl_bits:
    assert property (ctl_wr |=> test_mode == $past(reg_wdata[1])
      && port_swap == $past(reg_wdata[4])) else $error("control bits not taken");
  chk_first_write:
    assert property ($rose(test_busy) |=> f_we && f_addr == BST_FIRST_ADDR)
      else $error("fill did not begin at address zero");
  chk_addr_ascend:
    assert property (f_we && f_addr != BST_LAST_ADDR && !ctl_wr
      |=> f_we && f_addr == $past(f_addr) + 13'h1) else $error("fill address not stepping");
  chk_fill_count:
    assert property ($fell(test_busy) && !abort_ff |-> cnt_ff == 14'h2000)
      else $error("fill write count wrong");
  chk_addr_data:
    assert property (f_we && type_ff == 2'h1 |-> f_data == f_addr[7:0])
      else $error("address fill data wrong");
  chk_pattern_rot:
    assert property (f_we && type_ff == 2'h2 && f_addr != BST_LAST_ADDR && !ctl_wr
      |=> f_data == rotl($past(f_data), shift_ff)) else $error("pattern rotation wrong");
  chk_random_step:
    assert property (f_we && type_ff == 2'h0 && f_addr != BST_LAST_ADDR && !ctl_wr
      |=> f_data == ($past(f_data[0]) ? ($past(f_data) >> 1) ^ BST_LFSR_TAPS : $past(f_data) >> 1))
      else $error("random step wrong");
  chk_copy_steer:
    assert property (dma_re |=> port_swap
      ? (port_a_re && !port_b_re && port_a_addr == $past(dma_addr))
      : (port_b_re && !port_a_re && port_b_addr == $past(dma_addr)))
      else $error("copy read not steered");
endmodule // bst_top_props

bind bst_top bst_top_props bst_top_props_inst (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .dma_addr, .dma_re, .port_a_addr, .port_a_wdata, .port_a_we, .port_a_re, .port_b_addr,
  .port_b_wdata, .port_b_we, .port_b_re, .test_mode, .test_busy, .port_swap);

// File: tb/bst_sram_model.sv
// Dual-port buffer RAM model standing behind the two SRAM ports.
module bst_sram_model
(
  input  wire logic        clock,
  input  wire logic [12:0] port_a_addr,
  input  wire logic [7:0]  port_a_wdata,
  input  wire logic        port_a_we,
  input  wire logic        port_a_re,
  output logic      [7:0]  port_a_rdata,
  input  wire logic [12:0] port_b_addr,
  input  wire logic [7:0]  port_b_wdata,
  input  wire logic        port_b_we,
  input  wire logic        port_b_re,
  output logic      [7:0]  port_b_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:8191];

  // Writes land at the clock edge, one byte per port and cycle.
  always @(posedge clock)
  begin
    if (port_a_we) mem[port_a_addr] <= port_a_wdata;
    if (port_b_we) mem[port_b_addr] <= port_b_wdata;
  end

  // A port that is not reading shows inverted data, so stale bytes never pass.
  assign port_a_rdata = port_a_re ? mem[port_a_addr] : ~mem[port_a_addr];
  assign port_b_rdata = port_b_re ? mem[port_b_addr] : ~mem[port_b_addr];
endmodule // bst_sram_model

// File: tb/test_buffer_memory_self_test.sv
// Self-checking testbench for the buffer memory self-test block.
module test_buffer_memory_self_test
  import bst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, dma_re = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, dma_rdata, port_a_wdata, port_b_wdata;
  logic [7:0]  port_a_rdata, port_b_rdata, s8;
  logic [12:0] dma_addr = 13'h0, port_a_addr, port_b_addr;
  logic        port_a_we, port_b_we, port_a_re, port_b_re, test_mode, test_busy, port_swap;
  logic        rd1 = 1'b0, dr1 = 1'b0, dr2 = 1'b0;
  logic [7:0]  img [0:8191];
  logic [7:0]  reg_q[$], dma_q[$];
  logic [15:0] sum_exp;
  int          n_errors = 0, samples_checked = 0;
  integer      rs = 32'h0bc1a97b;

  bst_top bst_top_inst (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .dma_addr, .dma_re, .dma_rdata, .port_a_addr, .port_a_wdata, .port_a_we, .port_a_re,
    .port_a_rdata, .port_b_addr, .port_b_wdata, .port_b_we, .port_b_re, .port_b_rdata,
    .test_mode, .test_busy, .port_swap);
  bst_sram_model bst_sram_model_inst (.clock, .port_a_addr, .port_a_wdata, .port_a_we,
    .port_a_re, .port_a_rdata, .port_b_addr, .port_b_wdata, .port_b_we, .port_b_re,
    .port_b_rdata);

  always #25 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Read data stands one cycle after the strobe; copy data two cycles after its request.
  always @(posedge clock)
  begin
    rd1 <= reg_rd;
    dr1 <= dma_re;
    dr2 <= dr1;
    if (rd1 && reg_q.size() > 0) check({8'h00, reg_rdata}, {8'h00, reg_q.pop_front()});
    if (dr2 && dma_q.size() > 0) check({8'h00, dma_rdata}, {8'h00, dma_q.pop_front()});
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    reg_q.push_back(e);
    @(posedge clock);
    reg_rd   <= 1'b0;
  endtask

  // Copy engine reads one byte a cycle, first at a known address-fill spot.
  task automatic dma_sweep(input int n);
    logic [12:0] a;
    for (int k = 0; k < n; k++)
    begin
      @(posedge clock);
      a = (k == 0) ? 13'h0e2a : 13'($random(rs));
      dma_addr <= a;
      dma_re   <= 1'b1;
      dma_q.push_back(img[a]);
    end
    @(posedge clock);
    dma_re <= 1'b0;
  endtask

  // Builds the expected image and checksum, then runs one whole fill.
  task automatic run_fill(input logic [1:0] ft, input logic sw, input logic [2:0] sh,
                          input logic [7:0] sd);
    logic [7:0]  s;
    logic [15:0] t;
    logic [16:0] acc;
    int          n;
    s   = sd;
    acc = 17'h0;
    n   = 0;
    for (int i = 0; i < 8192; i++)
    begin
      img[i] = (ft == 2'h1) ? 8'(i) : s;
      if (ft == 2'h0) s = s[0] ? (s >> 1) ^ BST_LFSR_TAPS : s >> 1;
      t = {s, s} << sh;
      if (ft == 2'h2) s = t[15:8];
    end
    for (int i = 0; i < 8192; i += 2)
    begin
      acc = acc + {1'b0, img[i], img[i + 1]};
      acc = {1'b0, acc[15:0]} + {16'h0, acc[16]};
    end
    sum_exp = (ft == 2'h1) ? 16'hf807 : ~acc[15:0];
    wr(BST_OFS_SEED, sd);
    wr(BST_OFS_CTRL, {sh, sw, ft, 2'h3});
    for (int k = 0; k < 9000 && !(n > 0 && test_busy === 1'b0); k++)
    begin
      @(negedge clock);
      if (test_busy === 1'b1) n++;
    end
    check(16'(n), 16'h2001);
    rd(BST_OFS_SUM_LO, sum_exp[7:0]);
    rd(BST_OFS_SUM_HI, sum_exp[15:8]);
    rd(BST_OFS_SEED, s);
    rd(BST_OFS_CTRL, {sh, sw, ft, 2'h2});
    dma_sweep(12);
  endtask

  initial
  begin
    #(60000 * 50);
    n_errors++;
    report_and_stop;
  end

  initial
  begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    for (int a = 0; a < 5; a++) rd(4'(a), 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    wr(BST_OFS_CTRL, 8'hf2);
    rd(BST_OFS_CTRL, 8'hf2);
    check({14'h0, test_mode, port_swap}, 16'h0003);
    $display("test reset and control done");
    run_fill(2'h1, 1'b0, 3'h5, 8'h00);
    s8 = 8'($random(rs)) | 8'h01;
    run_fill(2'h0, 1'b1, 3'h3, s8);
    run_fill(2'h0, 1'b0, 3'h3, s8);
    run_fill(2'h0, 1'b0, 3'h0, 8'h00);
    run_fill(2'h2, 1'b1, 3'($random(rs)) | 3'h1, 8'($random(rs)));
    $display("test fills done");
    wr(BST_OFS_CTRL, 8'h0f);
    repeat (2) @(negedge clock);
    check({15'h0, test_busy}, 16'h0000);
    wr(BST_OFS_CTRL, 8'h01);
    repeat (2) @(negedge clock);
    check({15'h0, test_busy}, 16'h0000);
    wr(BST_OFS_CTRL, 8'h03);
    repeat (40) @(posedge clock);
    rd(BST_OFS_CTRL, 8'h03);
    wr(BST_OFS_CTRL, 8'h00);
    repeat (2) @(negedge clock);
    check({15'h0, test_busy}, 16'h0000);
    check({14'h0, port_a_we, port_b_we}, 16'h0000);
    rd(BST_OFS_SUM_LO, sum_exp[7:0]);
    rd(BST_OFS_SUM_HI, sum_exp[15:8]);
    $display("test refusal and abort done");
    repeat (4) @(posedge clock);
    report_and_stop;
  end
endmodule // test_buffer_memory_self_test
